/* rtl/tdhp_pkg.sv */
package tdhp_pkg;

  // ---------------------------------------------------------------------------
  // Unit addressing
  // ---------------------------------------------------------------------------
  localparam int         UNIT_W        = 3;        // Three address levels.
  localparam logic [2:0] UNIT_NUM_ZERO = 3'h0;     // Lowest unit number.
  localparam logic [2:0] UNIT_NUM_SEVEN = 3'h7;    // Highest unit number.

  // ---------------------------------------------------------------------------
  // Data widths
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 9;                       // Eight data bits plus parity.

  // ---------------------------------------------------------------------------
  // Motion timing
  // ---------------------------------------------------------------------------
  // One inch of streaming at normal and high speed, as clock counts.
  localparam int CLK_HZ          = 40_000_000;
  localparam int NORMAL_IPS      = 50;
  localparam int FAST_IPS        = 100;
  localparam int INCH_CYC_NORMAL = CLK_HZ / NORMAL_IPS;
  localparam int INCH_CYC_FAST   = CLK_HZ / FAST_IPS;
  localparam int REPOS_CYC       = 4000;           // Reposition cycle length.
  localparam int CNT_W           = 20;

  // ---------------------------------------------------------------------------
  // Command level positions in the captured command word
  // ---------------------------------------------------------------------------
  localparam int CMD_REV = 0;
  localparam int CMD_WRT = 1;
  localparam int CMD_WFM = 2;
  localparam int CMD_EDT = 3;
  localparam int CMD_ERS = 4;
  localparam int CMD_W   = 5;

  // Controller states.
  typedef enum logic [2:0] {
    TDHP_IDLE,
    TDHP_RUN,
    TDHP_WINDOW,
    TDHP_HOLD,
    TDHP_REPOS
  } tdhp_state_t;

endpackage

/* rtl/tdhp_port.sv */
// Implementation choices: two-stage input synchronisers and command capture on the trailing strobe edge.
`timescale 1ns/1ps
`default_nettype none
module tdhp_port
  import tdhp_pkg::*;
(
  // Clock and reset.
  input  wire  logic              sys_clk,
  input  wire  logic              srst,
  // Unit strap number of this drive.
  input  wire  logic [UNIT_W-1:0] my_unit_num,
  // Low-true host inputs, raw from the cable.
  input  wire  logic              unit_group_select_n,
  input  wire  logic              unit_select_hi_n,
  input  wire  logic              unit_select_lo_n,
  input  wire  logic              go_n,
  input  wire  logic              direction_reverse_n,
  input  wire  logic              write_not_read_n,
  input  wire  logic              write_tape_mark_n,
  input  wire  logic              edit_overwrite_n,
  input  wire  logic              erase_request_n,
  input  wire  logic              fast_speed_select_n,
  input  wire  logic              extended_gap_select_n,
  input  wire  logic              rewind_request_n,
  input  wire  logic              unload_request_n,
  input  wire  logic              load_online_request_n,
  input  wire  logic              final_char_flag_n,
  input  wire  logic              interface_enable_n,
  input  wire  logic [DATA_W-1:0] write_data_lines_n,
  // Drive internals: legality table, motion engine and media status.
  input  wire  logic [31:0]       legal_cmd_mask,
  input  wire  logic              fbusy_on_xfer_opt,
  input  wire  logic              xfer_done,
  input  wire  logic              window_open,
  input  wire  logic              motion_stopped,
  input  wire  logic [DATA_W-1:0] read_data,
  input  wire  logic [15:0]       status_in,
  // Engine command outputs.
  output logic                    cmd_start,
  output logic [CMD_W-1:0]        cmd_word,
  output logic                    motion_run,
  output logic                    repos_active,
  output logic                    fast_mode,
  output logic                    rewind_pulse,
  output logic                    unload_pulse,
  output logic                    load_pulse,
  output logic                    final_char,
  output logic                    long_gap,
  output logic [DATA_W-1:0]       write_data,
  // Open-collector outputs: one means pull the line low (true).
  output logic                    formatter_busy_flag_oe,
  output logic                    transfer_busy_flag_oe,
  output logic [DATA_W-1:0]       read_data_lines_oe,
  output logic [15:0]             status_lines_oe
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  localparam int NIN = 19 + DATA_W;
  wire  [NIN-1:0] raw_n = {unit_group_select_n, unit_select_hi_n, unit_select_lo_n, go_n,
    direction_reverse_n, write_not_read_n, write_tape_mark_n, edit_overwrite_n,
    erase_request_n, fast_speed_select_n, extended_gap_select_n, rewind_request_n,
    unload_request_n, load_online_request_n, final_char_flag_n, interface_enable_n,
    3'h7, write_data_lines_n};
  logic [NIN-1:0] s1_ff;    // First stage, read by the second only.
  logic [NIN-1:0] s2_ff;    // Second stage, usable.

  // Synchronisers reset to all high, which is false on the cable.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_ff <= '1;
      s2_ff <= '1;
    end else begin
      s1_ff <= raw_n;
      s2_ff <= s1_ff;
    end
  end

  // Low means true; an open line floats high and reads false.
  wire [NIN-1:0] tru = ~s2_ff;
  wire [UNIT_W-1:0] addr = tru[NIN-1 -: 3];
  wire sel      = (addr == my_unit_num);
  wire go       = tru[NIN-4];
  // Cable order is reverse, write, mark, edit, erase; the word puts reverse in bit 0.
  wire [CMD_W-1:0] lvls = {tru[NIN-9], tru[NIN-8], tru[NIN-7], tru[NIN-6], tru[NIN-5]};
  wire enable   = tru[DATA_W+3];

  // ---------------------------------------------------------------------------
  // Strobe edge detection
  // ---------------------------------------------------------------------------
  logic go_d_ff;  // Previous qualified strobe level.
  logic [CMD_W-1:0] lvl_d_ff; // Levels one cycle before the edge.
  wire  go_q    = go & sel;
  wire  go_fall = go_d_ff & ~go_q;
  wire  go_rise = ~go_d_ff & go_q;

  // Levels are taken one cycle early so skew at the edge does not corrupt them.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      go_d_ff  <= 1'b0;
      lvl_d_ff <= '0;
    end else begin
      go_d_ff  <= go_q;
      lvl_d_ff <= lvls;
    end
  end

  // ---------------------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------------------
  tdhp_state_t     st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CMD_W-1:0] cmd_ff, nxt_cmd;
  logic            start_ff, nxt_start;
  logic            fbusy_ff, nxt_fbusy;
  logic            dbusy_ff, nxt_dbusy;
  logic            fast_ff;

  wire legal     = legal_cmd_mask[lvl_d_ff];
  wire is_write  = cmd_ff[CMD_WRT];
  wire [CNT_W-1:0] inch_cyc = fast_ff ? CNT_W'(INCH_CYC_FAST) : CNT_W'(INCH_CYC_NORMAL);

  // Next-state decode for the sequencer.
  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_cmd   = cmd_ff;
    nxt_start = 1'b0;
    nxt_fbusy = fbusy_ff;
    nxt_dbusy = dbusy_ff;
    unique case (st_ff)
      TDHP_IDLE: begin
        // Command begins only on the trailing strobe edge, when legal.
        if (go_fall && legal) begin
          nxt_cmd   = lvl_d_ff;
          nxt_start = 1'b1;
          nxt_fbusy = 1'b1;
          nxt_dbusy = 1'b1;
          nxt_st    = TDHP_RUN;
        end
      end
      TDHP_RUN: begin
        if (xfer_done) begin
          nxt_dbusy = 1'b0;
          if (fbusy_on_xfer_opt && fast_ff) begin
            nxt_fbusy = 1'b0;
          end
          nxt_st = is_write ? TDHP_WINDOW : TDHP_IDLE;
        end
      end
      TDHP_WINDOW: begin
        // Streaming write reinstruct window; a held strobe extends it.
        if (go_rise && !window_open) begin
          nxt_cnt = '0;
          nxt_st  = TDHP_HOLD;
        end else if (go_fall && legal) begin
          nxt_cmd   = lvl_d_ff;
          nxt_start = 1'b1;
          nxt_fbusy = 1'b1;
          nxt_dbusy = 1'b1;
          nxt_st    = TDHP_RUN;
        end else if (!window_open) begin
          nxt_st = TDHP_IDLE;
        end
      end
      TDHP_HOLD: begin
        // Stream for up to one inch waiting for release.
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (go_fall && legal) begin
          nxt_cmd   = lvl_d_ff;
          nxt_start = 1'b1;
          nxt_fbusy = 1'b1;
          nxt_dbusy = 1'b1;
          nxt_st    = TDHP_RUN;
        end else if (cnt_ff >= inch_cyc - CNT_W'(1)) begin
          nxt_cnt = '0;
          nxt_st  = TDHP_REPOS;
        end
      end
      TDHP_REPOS: begin
        // Reposition before accepting the pending command.
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cnt_ff >= CNT_W'(REPOS_CYC - 1)) begin
          nxt_st = TDHP_IDLE;
        end
      end
      default: nxt_st = TDHP_IDLE;
    endcase
    // Formatter busy clears once motion ceases outside an active command.
    if (nxt_st == TDHP_IDLE && motion_stopped && !nxt_start) begin
      nxt_fbusy = 1'b0;
    end
    // Interface disable returns every unit to quiescent.
    if (!enable) begin
      nxt_st    = TDHP_IDLE;
      nxt_start = 1'b0;
      nxt_dbusy = 1'b0;
      nxt_fbusy = 1'b0;
    end
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff    <= TDHP_IDLE;
      cnt_ff   <= '0;
      cmd_ff   <= '0;
      start_ff <= 1'b0;
      fbusy_ff <= 1'b0;
      dbusy_ff <= 1'b0;
      fast_ff  <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      cmd_ff   <= nxt_cmd;
      start_ff <= nxt_start;
      fbusy_ff <= nxt_fbusy;
      dbusy_ff <= nxt_dbusy;
      fast_ff  <= sel & tru[NIN-10];
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign cmd_start    = start_ff;
  assign cmd_word     = cmd_ff;
  assign motion_run   = (st_ff != TDHP_IDLE) & enable;
  assign repos_active = (st_ff == TDHP_REPOS);
  assign fast_mode    = fast_ff;
  assign rewind_pulse = sel & enable & tru[NIN-12];
  assign unload_pulse = sel & enable & tru[NIN-13];
  assign load_pulse   = sel & enable & tru[NIN-14];
  assign final_char   = tru[NIN-15];
  assign long_gap     = tru[NIN-11];
  assign write_data   = tru[DATA_W-1:0];
  // Only the addressed unit pulls shared lines; others stay released.
  assign formatter_busy_flag_oe = sel & fbusy_ff;
  assign transfer_busy_flag_oe  = sel & dbusy_ff;
  assign read_data_lines_oe     = sel ? read_data : '0;
  assign status_lines_oe        = sel ? status_in : '0;

endmodule
`default_nettype wire

/* verification/tdhp_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module tdhp_props (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        srst,
  // Unit strap, low-true cable side, and the legality mask.
  input wire logic [2:0]  my_unit_num,
  input wire logic        unit_group_select_n,
  input wire logic        unit_select_hi_n,
  input wire logic        unit_select_lo_n,
  input wire logic        go_n,
  input wire logic        direction_reverse_n,
  input wire logic        write_not_read_n,
  input wire logic        write_tape_mark_n,
  input wire logic        edit_overwrite_n,
  input wire logic        erase_request_n,
  input wire logic        rewind_request_n,
  input wire logic        load_online_request_n,
  input wire logic        interface_enable_n,
  input wire logic [31:0] legal_cmd_mask,
  // Drive side.
  input wire logic        cmd_start,
  input wire logic [4:0]  cmd_word,
  input wire logic        rewind_pulse,
  input wire logic        load_pulse,
  input wire logic        formatter_busy_flag_oe,
  input wire logic        transfer_busy_flag_oe,
  input wire logic [8:0]  read_data_lines_oe,
  input wire logic [15:0] status_lines_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Addressed when the three levels, read as true-low, give our number.
  wire logic       sel = {~unit_group_select_n, ~unit_select_hi_n, ~unit_select_lo_n} == my_unit_num;
  // Command levels in captured-word order.
  wire logic [4:0] lv  = ~{erase_request_n, edit_overwrite_n, write_tape_mark_n,
                           write_not_read_n, direction_reverse_n};

  a_go_starts_cmd: assert property (cmd_start |-> !$past(go_n, 4) || !$past(go_n, 5))
    else $error("start without strobe");
  a_start_sets_busy: assert property (cmd_start |-> formatter_busy_flag_oe && transfer_busy_flag_oe)
    else $error("busy not raised at start");
  a_legal_only: assert property (cmd_start |-> legal_cmd_mask[cmd_word])
    else $error("illegal command started");
  a_word_from_levels: assert property (cmd_start |-> cmd_word == $past(lv, 4))
    else $error("command word differs from levels");
  a_disable_quiet: assert property (interface_enable_n [*5] |-> !cmd_start && !formatter_busy_flag_oe)
    else $error("activity while disabled");
  a_unsel_released: assert property (!sel [*5] |-> !transfer_busy_flag_oe
    && read_data_lines_oe == 9'h000 && status_lines_oe == 16'h0000)
    else $error("unaddressed unit drives lines");
  a_rewind_synced: assert property (rewind_pulse |-> !$past(rewind_request_n, 2))
    else $error("rewind without request");
  a_load_enabled: assert property (load_pulse |-> !$past(load_online_request_n, 2)
    && !$past(interface_enable_n, 2))
    else $error("load without enabled request");
endmodule
bind tdhp_port tdhp_props u_props (.*);
`default_nettype wire

/* verification/tdhp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Controller model: one command per request
// ----------------------------------------
module tdhp_host (
  input  wire logic       sys_clk,
  input  wire logic       req,
  input  wire logic       hold,
  input  wire logic [2:0] unit,
  input  wire logic [4:0] cmd,
  output logic            go_n,
  output logic [2:0]      addr_n,
  output logic [4:0]      cmd_n
);
  logic [3:0] cnt_ff = 4'h0; // Sequence step, zero when idle.

  // Step runs 1..15 and wraps to idle, so levels outlast the strobe.
  always_ff @(posedge sys_clk) begin
    if (req) begin
      cnt_ff <= 4'h1;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  // Address held as a level; released command lines float high, i.e. false.
  assign addr_n = ~unit;
  assign cmd_n  = (cnt_ff != 4'h0 || hold) ? ~cmd : 5'h1f;
  // Strobe low for steps 3..6, or held low to stretch a write window.
  assign go_n   = !((cnt_ff >= 4'h3 && cnt_ff <= 4'h6) || hold);
endmodule
`default_nettype wire

/* verification/tdhp_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tdhp_port_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic sys_clk = 1'b0, srst = 1'b1, req = 1'b0, xfer_done = 1'b0;
  logic [2:0] h_unit = 3'h5, my_unit_num = 3'h5;
  logic [4:0] h_cmd = 5'h00;
  logic fast_speed_select_n = 1'b1, extended_gap_select_n = 1'b1, rewind_request_n = 1'b1;
  logic unload_request_n = 1'b1, load_online_request_n = 1'b1, final_char_flag_n = 1'b1;
  logic interface_enable_n = 1'b0, fbusy_on_xfer_opt = 1'b0, window_open = 1'b0;
  logic motion_stopped = 1'b1, hold = 1'b0;
  logic [8:0] write_data_lines_n = 9'h1ff, read_data = 9'h0a5;
  logic [15:0] status_in = 16'h00c3;
  logic [31:0] legal_cmd_mask = 32'h0001_0116; // Single-level words only.
  wire logic go_n;
  wire logic [2:0] addr_n;
  wire logic [4:0] cmd_n;
  logic cmd_start, motion_run, repos_active, fast_mode, rewind_pulse, unload_pulse, load_pulse;
  logic final_char, long_gap, formatter_busy_flag_oe, transfer_busy_flag_oe, hit, f;
  logic [4:0] cmd_word, w;
  logic [8:0] write_data, read_data_lines_oe;
  logic [15:0] status_lines_oe;
  logic [2:0] s;
  int fails = 0, num_checks = 0;

  tdhp_host u_host (.sys_clk(sys_clk), .req(req), .hold(hold), .unit(h_unit), .cmd(h_cmd),
    .go_n(go_n), .addr_n(addr_n), .cmd_n(cmd_n));
  tdhp_port DUT (.*, .unit_group_select_n(addr_n[2]), .unit_select_hi_n(addr_n[1]),
    .unit_select_lo_n(addr_n[0]), .direction_reverse_n(cmd_n[0]), .write_not_read_n(cmd_n[1]),
    .write_tape_mark_n(cmd_n[2]), .edit_overwrite_n(cmd_n[3]), .erase_request_n(cmd_n[4]));

  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One host command, then completion; busy must clear once the transfer ends.
  task automatic send(input logic [2:0] u, input logic [4:0] c);
    h_unit <= u;
    h_cmd <= c;
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    hit = 1'b0;
    repeat (16) begin
      @(posedge sys_clk);
      #1;
      if (cmd_start === 1'b1) begin
        hit = 1'b1;
        w = cmd_word;
      end
    end
    f = fast_mode;
    @(posedge sys_clk);
    xfer_done <= 1'b1;
    @(posedge sys_clk);
    xfer_done <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check("busy", {formatter_busy_flag_oe, transfer_busy_flag_oe}, 2'b00);
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every unit number in turn; only our own strap answers.
  task automatic t_units;
    for (int u = 0; u < 8; u++) begin
      send(u[2:0], 5'h02);
      check("start", hit, u == 5);
      check("rdata", read_data_lines_oe, (u == 5) ? 9'h0a5 : 9'h000);
      check("status", status_lines_oe, (u == 5) ? 16'h00c3 : 16'h0000);
    end
  endtask
  // Each command level alone lands in its own word bit.
  task automatic t_cmds;
    for (int k = 0; k < 5; k++) begin
      send(3'h5, 5'h01 << k);
      check("word", w, 5'h01 << k);
    end
  endtask
  // Undefined word, then a disabled interface: neither may start.
  task automatic t_refuse;
    send(3'h5, 5'h1f);
    check("illegal", hit, 1'b0);
    interface_enable_n <= 1'b1;
    send(3'h5, 5'h02);
    check("disabled", hit, 1'b0);
    interface_enable_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // Fast select on, then off.
  task automatic t_fast;
    fast_speed_select_n <= 1'b0;
    send(3'h5, 5'h02);
    check("fast", {hit, f}, 2'b11);
    fast_speed_select_n <= 1'b1;
    send(3'h5, 5'h02);
    check("normal", {hit, f}, 2'b10);
  endtask
  // Write window stretched by a held strobe; release resumes the next command.
  task automatic t_hold;
    window_open <= 1'b1;
    h_unit <= 3'h5;
    h_cmd <= 5'h02;
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (16) @(posedge sys_clk);
    xfer_done <= 1'b1;
    @(posedge sys_clk);
    xfer_done <= 1'b0;
    hold <= 1'b1;
    repeat (2) @(posedge sys_clk);
    window_open <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    check("stream", {motion_run, repos_active, cmd_start}, 3'b100);
    hold <= 1'b0;
    hit = 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      if (cmd_start === 1'b1) begin
        hit = 1'b1;
      end
    end
    check("resume", hit, 1'b1);
    @(posedge sys_clk);
    xfer_done <= 1'b1;
    @(posedge sys_clk);
    xfer_done <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check("hold busy", {formatter_busy_flag_oe, transfer_busy_flag_oe, motion_run}, 3'b000);
    @(posedge sys_clk);
  endtask
  // Request pulses and level copies arrive inverted to true-high.
  task automatic t_misc;
    s = 3'b000;
    {rewind_request_n, unload_request_n, load_online_request_n} <= 3'b000;
    write_data_lines_n <= 9'h15a;
    {final_char_flag_n, extended_gap_select_n} <= 2'b00;
    repeat (2) @(posedge sys_clk);
    {rewind_request_n, unload_request_n, load_online_request_n} <= 3'b111;
    repeat (5) begin
      @(posedge sys_clk);
      #1;
      s = s | {rewind_pulse === 1'b1, unload_pulse === 1'b1, load_pulse === 1'b1};
    end
    check("pulses", s, 3'b111);
    check("wdata", write_data, 9'h0a5);
    check("levels", {final_char, long_gap}, 2'b11);
    @(posedge sys_clk);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check("idle", {cmd_start, formatter_busy_flag_oe}, 2'b00);
    @(posedge sys_clk);
    t_units;
    t_cmds;
    t_refuse;
    t_fast;
    t_hold;
    t_misc;
    test_done;
  end
  // Watchdog well beyond the expected few hundred cycles.
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
